/* src/interrupt_vector_map.v */
// interrupt vector mapper: gating, wakeup and vector address forming
`timescale 1ns/1ps
`include "irq_vector_map.vh"
module interrupt_vector_map (
	input wire clk_sys_i, // system bus clock
	input wire rst_n_i, // sync reset, active low
	input wire i_mask_i, // maskable-interrupt flag, 1 masks
	input wire stop_mode_i, // part is in stop
	input wire wait_mode_i, // part is in wait
	input wire base_we_i, // write strobe for base register
	input wire [`VEC_ADDR_W-1:0] base_wdata_i, // new base value
	input wire supply_high_flag_i, // supply high event
	input wire supply_low_flag_i, // supply low event
	input wire supply_high_irq_enable_i, // high-voltage enable
	input wire supply_low_irq_enable_i, // low-voltage enable
	input wire periodic_flag_i, // periodic wakeup event
	input wire periodic_wakeup_irq_enable_i, // periodic enable
	input wire [3:0] overcurrent_flag_i, // pins 7,5,3,1 flags
	input wire [3:0] portp_overcurrent_enable_i, // pins 7,5,3,1 enables
	input wire timer_ch0_flag_i, // second timer channel 0 flag
	input wire channel_zero_irq_enable_i, // channel 0 enable
	input wire timer_ch1_flag_i, // second timer channel 1 flag
	input wire channel_one_irq_enable_i, // channel 1 enable
	output reg irq_req_o, // request to core
	output reg [`VEC_ADDR_W-1:0] vector_addr_o, // vector address
	output reg wakeup_o, // wake the part
	output reg [`VEC_ADDR_W-1:0] vector_base_o // base register readback
);
	// ======================================
	// local constants
	localparam SRC_N = `SRC_COUNT;
	localparam ADDR_W = `VEC_ADDR_W;
	localparam OC_N = `OC_PIN_COUNT;
	// bit i says whether source i may end stop or wait
	localparam [SRC_N-1:0] STOP_WAKE_SET = `WAKE_STOP_MASK;
	localparam [SRC_N-1:0] WAIT_WAKE_SET = `WAKE_WAIT_MASK;
	localparam [ADDR_W-1:0] BASE_RST = `VEC_BASE_RST;

	// ======================================
	// vector base register
	// the whole table moves with the base; offsets stay fixed
	reg [ADDR_W-1:0] vector_base_reg;
	reg [ADDR_W-1:0] next_vector_base;

	always @* begin
		next_vector_base = vector_base_reg;
		if (base_we_i) begin
			next_vector_base = base_wdata_i;
		end
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			vector_base_reg <= BASE_RST;
		end else begin
			vector_base_reg <= next_vector_base;
		end
	end

	// ======================================
	// supply monitor source: two events, each with its own enable
	// either event alone is enough to raise the shared request
	wire supply_hi_req;
	wire supply_lo_req;
	wire supply_req;

	assign supply_hi_req = supply_high_flag_i & supply_high_irq_enable_i;
	assign supply_lo_req = supply_low_flag_i & supply_low_irq_enable_i;
	assign supply_req = supply_hi_req | supply_lo_req;

	// ======================================
	// port P over-current source: bits 3..0 are pins 7, 5, 3 and 1
	wire [OC_N-1:0] oc_pin_req;
	wire oc_req;
	genvar j;

	generate
		for (j = 0; j < OC_N; j = j + 1) begin : g_oc_pin
			assign oc_pin_req[j] = overcurrent_flag_i[j] &
				portp_overcurrent_enable_i[j];
		end
	endgenerate

	// any enabled pin raises the one shared request
	assign oc_req = |oc_pin_req;

	// ======================================
	// periodic wakeup source
	wire periodic_req;

	assign periodic_req = periodic_flag_i &
		periodic_wakeup_irq_enable_i;

	// ======================================
	// second timer sources, one enable bit per channel
	wire timer_ch0_req;
	wire timer_ch1_req;

	assign timer_ch0_req = timer_ch0_flag_i &
		channel_zero_irq_enable_i;
	assign timer_ch1_req = timer_ch1_flag_i &
		channel_one_irq_enable_i;

	// ======================================
	// source vector; reserved slots have no entry, so cannot request
	wire [SRC_N-1:0] local_req;

	assign local_req[`SRC_SUPPLY] = supply_req;
	assign local_req[`SRC_OVERCURRENT] = oc_req;
	assign local_req[`SRC_PERIODIC] = periodic_req;
	assign local_req[`SRC_TIMER_CH0] = timer_ch0_req;
	assign local_req[`SRC_TIMER_CH1] = timer_ch1_req;

	// ======================================
	// masking and wake qualification, per source
	// the mask flag holds back the request only; wakeup ignores it
	wire [SRC_N-1:0] pend;
	wire [SRC_N-1:0] stop_hit;
	wire [SRC_N-1:0] wait_hit;
	wire stop_wake;
	wire wait_wake;
	genvar i;

	generate
		for (i = 0; i < SRC_N; i = i + 1) begin : g_src
			assign pend[i] = local_req[i] & ~i_mask_i;
			assign stop_hit[i] = local_req[i] & STOP_WAKE_SET[i];
			assign wait_hit[i] = local_req[i] & WAIT_WAKE_SET[i];
		end
	endgenerate

	assign stop_wake = |stop_hit;
	assign wait_wake = |wait_hit;

	// ======================================
	// priority select
	// sources enter in descending offset order; lowest index wins
	wire any_pend;
	wire [ADDR_W-1:0] win_ofs;

	vector_select u_sel (
		.pend_i(pend),
		.any_o(any_pend),
		.ofs_o(win_ofs)
	);

	// ======================================
	// slot guard: a request leaves only through an implemented slot,
	// so a bad select can never send the core into a reserved one
	reg slot_ok;

	always @* begin
		slot_ok = 1'b0;
		case (win_ofs)
		`OFS_SUPPLY: slot_ok = 1'b1;
		`OFS_OVERCURRENT: slot_ok = 1'b1;
		`OFS_PERIODIC: slot_ok = 1'b1;
		`OFS_TIMER_CH0: slot_ok = 1'b1;
		`OFS_TIMER_CH1: slot_ok = 1'b1;
		default: slot_ok = 1'b0;
		endcase
	end

	// ======================================
	// vector address forming
	// one spare bit takes the carry, which is dropped on purpose:
	// the address space of the table is 15 bits wide
	wire [ADDR_W:0] addr_sum;

	assign addr_sum = {1'b0, vector_base_reg} + {1'b0, win_ofs};

	// ======================================
	// next output values
	reg next_irq_req;
	reg [ADDR_W-1:0] next_vector_addr;
	reg next_wakeup;

	always @* begin
		next_irq_req = any_pend & slot_ok;
		next_vector_addr = addr_sum[ADDR_W-1:0];
		next_wakeup = 1'b0;
		if (stop_mode_i & stop_wake) begin
			next_wakeup = 1'b1;
		end
		if (wait_mode_i & wait_wake) begin
			next_wakeup = 1'b1;
		end
	end

	// ======================================
	// registered outputs, one flip-flop stage each
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_req_o <= 1'b0;
		end else begin
			irq_req_o <= next_irq_req;
		end
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			vector_addr_o <= BASE_RST;
		end else begin
			vector_addr_o <= next_vector_addr;
		end
	end

	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wakeup_o <= 1'b0;
		end else begin
			wakeup_o <= next_wakeup;
		end
	end

	// copy taken from the register itself, so it agrees with the address
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			vector_base_o <= BASE_RST;
		end else begin
			vector_base_o <= vector_base_reg;
		end
	end
endmodule // interrupt_vector_map

/* src/irq_vector_map.vh */
// constants for the interrupt vector mapper
// Overview of operation
// - vector address is base plus offset, 15 bits
// - supply monitor at 0x140, wait wake only
// - periodic wakeup at 0x100, wakes stop and wait
// - port P over-current at 0x108, wait only
// - second timer channel 0 at 0x0AC
// - second timer channel 1 at 0x0A8
// - higher offset wins when several pending
// - base comes from writable base register
`ifndef IRQ_VECTOR_MAP_VH
`define IRQ_VECTOR_MAP_VH
`define VEC_ADDR_W 15
`define VEC_BASE_RST 15'h7E00
`define OFS_SUPPLY 15'h0140
`define OFS_PERIODIC 15'h0100
`define OFS_OVERCURRENT 15'h0108
`define OFS_TIMER_CH0 15'h00AC
`define OFS_TIMER_CH1 15'h00A8
`define SRC_COUNT 5
`define SRC_SUPPLY 0
`define SRC_OVERCURRENT 1
`define SRC_PERIODIC 2
`define SRC_TIMER_CH0 3
`define SRC_TIMER_CH1 4
`define WAKE_STOP_MASK 5'h04
`define WAKE_WAIT_MASK 5'h1F
`define OC_PIN_COUNT 4
`endif

/* src/vector_select.v */
// priority select of pending sources onto one vector offset
`timescale 1ns/1ps
`include "irq_vector_map.vh"
module vector_select (
	input wire [`SRC_COUNT-1:0] pend_i, // gated pending sources
	output reg any_o, // some source pending
	output reg [`VEC_ADDR_W-1:0] ofs_o // offset of winner
);
	// sources are listed by descending offset, so lowest index wins
	integer k;
	always @* begin
		any_o = 1'b0;
		ofs_o = {`VEC_ADDR_W{1'b0}};
		for (k = `SRC_COUNT - 1; k >= 0; k = k - 1) begin
			if (pend_i[k]) begin
				any_o = 1'b1;
				case (k)
				`SRC_SUPPLY: ofs_o = `OFS_SUPPLY;
				`SRC_OVERCURRENT: ofs_o = `OFS_OVERCURRENT;
				`SRC_PERIODIC: ofs_o = `OFS_PERIODIC;
				`SRC_TIMER_CH0: ofs_o = `OFS_TIMER_CH0;
				default: ofs_o = `OFS_TIMER_CH1;
				endcase
			end
		end
	end
endmodule // vector_select

/* tb/interrupt_vector_map_assertions.sv */
// checker: gating, wakeup and base of the vector mapper
`timescale 1ns/1ps
module ivm_chk(input wire clk_sys_i,rst_n_i,i_mask_i,stop_mode_i,
	wait_mode_i,base_we_i,supply_high_flag_i,supply_low_flag_i,
	supply_high_irq_enable_i,supply_low_irq_enable_i,periodic_flag_i,
	periodic_wakeup_irq_enable_i,irq_req_o,wakeup_o,
	input wire [14:0] base_wdata_i,vector_addr_o,vector_base_o);
	wire s=supply_high_flag_i&supply_high_irq_enable_i|
		supply_low_flag_i&supply_low_irq_enable_i;
	wire p=periodic_flag_i&periodic_wakeup_irq_enable_i;
	wire q=stop_mode_i&!wait_mode_i&!p;
	wire [14:0] d=vector_addr_o-vector_base_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	AST_SUP: assert property (!i_mask_i&s |=> d==15'h0140)
		else $error("bad supply vector");
	AST_PER: assert property (!i_mask_i&p |=> irq_req_o)
		else $error("no periodic request");
	AST_MASK: assert property (i_mask_i |=> !irq_req_o)
		else $error("masked request");
	AST_SLOT: assert property (irq_req_o |-> d[14:9]==0)
		else $error("vector outside table");
	AST_WAKE: assert property (stop_mode_i&p |=> wakeup_o)
		else $error("no wake from stop");
	AST_STOP: assert property (q |=> !wakeup_o)
		else $error("wake from stop");
	AST_BASE: assert property (base_we_i ##1 !base_we_i |=>
		vector_base_o==$past(base_wdata_i,2)) else $error("base not loaded");
	AST_RES: assert property ($rose(rst_n_i) |-> !irq_req_o)
		else $error("request out of reset");
endmodule // ivm_chk
bind interrupt_vector_map ivm_chk chk(.*);

/* tb/core_model.sv */
// core model: takes the vector while a request stands
`timescale 1ns/1ps
module core_model(input wire clk_sys_i,irq_req_o,
	input wire [14:0] vector_addr_o,output reg [14:0] fetch_o=0);
	always @(posedge clk_sys_i) if (irq_req_o) fetch_o<=vector_addr_o;
endmodule // core_model

/* tb/interrupt_vector_map_test.sv */
// self-checking bench for the vector mapper
`timescale 1ns/1ps
module interrupt_vector_map_test;
	reg clk_sys_i=0,rst_n_i=0,m=0,st=0,we=0,wt=0;
	reg [4:0] f=0,e=0;
	reg [14:0] bw=15'h7FF0;
	wire irq,wk;
	wire [14:0] va,vb,fa;
	integer error_cnt=0,compares=0,cyc=0,k;
	always #10 clk_sys_i=~clk_sys_i;
	interrupt_vector_map dut(.clk_sys_i,.rst_n_i,.i_mask_i(m),
		.stop_mode_i(st),.wait_mode_i(wt),.base_we_i(we),.base_wdata_i(bw),
		.supply_high_flag_i(f[0]),.supply_low_flag_i(f[0]),
		.supply_high_irq_enable_i(e[0]),.supply_low_irq_enable_i(e[0]),
		.overcurrent_flag_i({f[1],3'h0}),
		.portp_overcurrent_enable_i({4{e[1]}}),
		.periodic_flag_i(f[2]),.periodic_wakeup_irq_enable_i(e[2]),
		.timer_ch0_flag_i(f[3]),.channel_zero_irq_enable_i(e[3]),
		.timer_ch1_flag_i(f[4]),.channel_one_irq_enable_i(e[4]),
		.irq_req_o(irq),.vector_addr_o(va),.wakeup_o(wk),.vector_base_o(vb));
	core_model core(.clk_sys_i,.irq_req_o(irq),.vector_addr_o(va),.fetch_o(fa));
	task chk(input [15:0] g,x);
		compares=compares+1;
		if (g!==x) begin
			error_cnt=error_cnt+1;
			$display("[FAIL] %0t got %h exp %h",$time,g,x);
		end
	endtask
	// inputs land on a falling edge, outputs read one cycle later
	task put(input [4:0] nf,ne,input nm);
		@(negedge clk_sys_i);
		{f,e,m}={nf,ne,nm};
		@(negedge clk_sys_i);
	endtask
	function [14:0] ofs(input integer i);
		ofs=i==0?15'h0140:i==1?15'h0108:i==2?15'h0100:i==3?15'h00AC:15'h00A8;
	endfunction
	task t_base;
		chk(vb,15'h7E00);
		we=1;
		put(0,0,0);
		we=0;
		chk(vb,15'h7FF0);
	endtask
	// base near the top so every sum wraps at 15 bits
	task t_prio;
		for (k=0;k<5;k=k+1) begin
			put(5'h1F<<k,5'h1F,0);
			chk({irq,va},{1'b1,15'h7FF0+ofs(k)});
		end
	endtask
	task t_gate;
		put(5'h1F,5'h1F,1);
		chk(irq,0);
		chk(fa,15'h0098);
		put(5'h1F,0,0);
		chk(irq,0);
		st=1;
		put(5'h04,5'h1F,1);
		chk(wk,1);
		put(5'h1B,5'h1F,1);
		chk(wk,0);
		st=0;
		wt=1;
		put(5'h01,5'h1F,1);
		chk({irq,wk},2'b01);
		put(5'h10,5'h1F,0);
		chk({irq,wk},2'b11);
	endtask
	task give_verdict;
		$display("errors %0d compares %0d",error_cnt,compares);
		if (error_cnt==0&&compares>0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc=cyc+1;
		if (cyc==300) begin
			error_cnt=error_cnt+1;
			give_verdict;
		end
	end
	initial begin
		repeat (6) @(negedge clk_sys_i);
		rst_n_i=1;
		t_base;
		t_prio;
		t_gate;
		give_verdict;
	end
endmodule // interrupt_vector_map_test
